// *** include/rtsp_pkg.sv ***
// Shared constants and types of the real-time trace status port.
// Assumes one processor clock domain and one link clock domain.
package rtsp_pkg;
  localparam int NIB_W = 4;
  localparam int DATA_W = 32;
  localparam int BYTES_W = 3;
  localparam int FIFO_DEPTH = 2;
  localparam int FIFO_AW = 1;
  localparam int SYNC_W = 9;

  // Status nibble encodings
  localparam logic [3:0] ST_CONTINUE = 4'h0;
  localparam logic [3:0] ST_BEGIN = 4'h1;
  localparam logic [3:0] ST_USER = 4'h3;
  localparam logic [3:0] ST_MARK_WRITE = 4'h4;
  localparam logic [3:0] ST_BRANCH = 4'h5;
  localparam logic [3:0] ST_EXC_RET = 4'h7;
  localparam logic [3:0] ST_MARKER_BASE = 4'h7;
  localparam logic [3:0] ST_EXC = 4'hc;
  localparam logic [3:0] ST_EMU = 4'hd;
  localparam logic [3:0] ST_STOP = 4'he;
  localparam logic [3:0] ST_HALT = 4'hf;

  // Reset values of the output registers
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [3:0] DATA_RESET = 4'h0;

  // Target byte setting: none, or 2, 3, 4 bytes
  localparam logic [1:0] TGT_NONE = 2'h0;

  typedef enum logic [2:0] {
    EV_BEGIN = 3'h0,
    EV_USER = 3'h1,
    EV_TRIGGER = 3'h2,
    EV_DATA_WRITE = 3'h3,
    EV_BRANCH = 3'h4,
    EV_PC_SYNC = 3'h5,
    EV_EXC_RET = 3'h6
  } rtsp_event_t;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } rtsp_size_t;

  typedef enum logic [1:0] {
    LS_IDLE = 2'h0,
    LS_MARK = 2'h1,
    LS_DATA = 2'h2
  } rtsp_link_state_t;

  typedef struct packed {
    logic [3:0] code;
    logic [BYTES_W-1:0] bytes;
    logic [DATA_W-1:0] value;
  } rtsp_entry_t;

  localparam int ENTRY_W = 4 + BYTES_W + DATA_W;
endpackage : rtsp_pkg

// *** include/rtsp_fifo_if.sv ***
// Push and pop signals of the trace entry queue.
// Push side lives on the processor clock, pop side on the link clock.
interface rtsp_fifo_if #(parameter int W = 39);
  logic wr_valid;
  logic wr_ready;
  logic [W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [W-1:0] rd_data;

  modport push(output wr_valid, output wr_data, input wr_ready);
  modport pop(input rd_valid, input rd_data, output rd_ready);
  modport store(input wr_valid, input wr_data, output wr_ready,
                output rd_valid, output rd_data, input rd_ready);
endinterface : rtsp_fifo_if

// *** core/rtsp_async_fifo.sv ***
// Two-clock entry queue with gray-coded pointers.
// Assumes each reset is released synchronously to its own clock.
module rtsp_async_fifo #(
  parameter int W = 39,
  parameter int AW = 1
) (
  // Clocks and resets
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_clk_link,
  input wire logic i_link_reset_n,
  // Queue ports
  rtsp_fifo_if.store q
);
  localparam int PW = AW + 1;
  localparam logic [PW-1:0] FULL_X = PW'(3 << (PW - 2));
  localparam logic [PW-1:0] ONE = PW'(1);

  logic [W-1:0] mem_q [2**AW];
  logic [PW-1:0] wbin_q, wbin_d, wgray_q, wgray_d, rg_s1_q, rg_s2_q;
  logic [PW-1:0] rbin_q, rbin_d, rgray_q, rgray_d, wg_s1_q, wg_s2_q;
  logic push, pop;

  always_comb begin
    q.wr_ready = (wgray_q ^ rg_s2_q) != FULL_X;
    push = q.wr_valid & q.wr_ready;
    wbin_d = wbin_q + (push ? ONE : '0);
    wgray_d = wbin_d ^ (wbin_d >> 1);
    q.rd_valid = rgray_q != wg_s2_q;
    q.rd_data = mem_q[rbin_q[AW-1:0]];
    pop = q.rd_valid & q.rd_ready;
    rbin_d = rbin_q + (pop ? ONE : '0);
    rgray_d = rbin_d ^ (rbin_d >> 1);
  end

  // Storage carries no reset; the pointers guard every read
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem_q[wbin_q[AW-1:0]] <= q.wr_data;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wbin_q <= '0;
      wgray_q <= '0;
      rg_s1_q <= '0;
      rg_s2_q <= '0;
    end else begin
      wbin_q <= wbin_d;
      wgray_q <= wgray_d;
      rg_s1_q <= rgray_q;
      rg_s2_q <= rg_s1_q;
    end
  end

  always_ff @(posedge i_clk_link or negedge i_link_reset_n) begin
    if (!i_link_reset_n) begin
      rbin_q <= '0;
      rgray_q <= '0;
      wg_s1_q <= '0;
      wg_s2_q <= '0;
    end else begin
      rbin_q <= rbin_d;
      rgray_q <= rgray_d;
      wg_s1_q <= wgray_q;
      wg_s2_q <= wg_s1_q;
    end
  end
endmodule : rtsp_async_fifo

// *** core/rtsp_trace_port.sv ***
// Real-time trace status port: status nibble, debug data nibble, strobe clock.
// Assumes the core offers one trace event per handshake and holds it while stalled;
// the link clock runs freely and is unrelated to the processor clock.
module rtsp_trace_port (
  // Processor clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // Link clock
  input wire logic i_clk_link,
  // Trace events from the core
  input wire logic i_evt_valid,
  input wire rtsp_pkg::rtsp_event_t i_evt_kind,
  input wire logic i_evt_variant,
  input wire rtsp_pkg::rtsp_size_t i_evt_size,
  input wire logic [rtsp_pkg::DATA_W-1:0] i_evt_value,
  output logic o_core_stall,
  // Multi-cycle processor modes
  input wire logic i_exc_active,
  input wire logic i_emu_active,
  input wire logic i_stopped,
  input wire logic i_halted,
  // Configuration and breakpoint state
  input wire logic [1:0] i_target_bytes,
  input wire logic i_status_clock_disable,
  input wire logic [rtsp_pkg::NIB_W-1:0] i_breakpoint_status,
  // Trace pins
  output logic [rtsp_pkg::NIB_W-1:0] o_processor_status_nibble,
  output logic [rtsp_pkg::NIB_W-1:0] o_debug_data_nibble,
  output logic o_status_strobe_clock,
  output logic o_all_status_high
);
  localparam int NIB_CNT_W = rtsp_pkg::BYTES_W + 1;

  rtsp_fifo_if #(.W(rtsp_pkg::ENTRY_W)) q_if ();

  rtsp_pkg::rtsp_entry_t push_entry;
  rtsp_pkg::rtsp_entry_t pop_entry;
  logic link_rst_s1_q;
  logic link_reset_n_q;

  // Core side: turn an event into an entry

  function automatic logic [3:0] event_code(input rtsp_pkg::rtsp_event_t kind);
    logic [3:0] code;
    code = rtsp_pkg::ST_BEGIN;
    case (kind)
      rtsp_pkg::EV_BEGIN: code = rtsp_pkg::ST_BEGIN;
      rtsp_pkg::EV_USER: code = rtsp_pkg::ST_USER;
      rtsp_pkg::EV_TRIGGER: code = rtsp_pkg::ST_MARK_WRITE;
      rtsp_pkg::EV_DATA_WRITE: code = rtsp_pkg::ST_MARK_WRITE;
      rtsp_pkg::EV_BRANCH: code = rtsp_pkg::ST_BRANCH;
      rtsp_pkg::EV_PC_SYNC: code = rtsp_pkg::ST_BRANCH;
      rtsp_pkg::EV_EXC_RET: code = rtsp_pkg::ST_EXC_RET;
      default: code = rtsp_pkg::ST_BEGIN;
    endcase
    return code;
  endfunction : event_code

  always_comb begin
    push_entry.code = event_code(i_evt_kind);
    push_entry.value = i_evt_value;
    push_entry.bytes = '0;
    if (i_evt_kind == rtsp_pkg::EV_DATA_WRITE) begin
      case (i_evt_size)
        rtsp_pkg::SZ_BYTE: push_entry.bytes = 3'h1;
        rtsp_pkg::SZ_WORD: push_entry.bytes = 3'h2;
        default: push_entry.bytes = 3'h4;
      endcase
    end
    if ((i_evt_kind == rtsp_pkg::EV_BRANCH || i_evt_kind == rtsp_pkg::EV_EXC_RET)
        && i_evt_variant && i_target_bytes != rtsp_pkg::TGT_NONE) begin
      push_entry.bytes = {1'b0, i_target_bytes} + 3'h1;
    end
    q_if.wr_valid = i_evt_valid;
    q_if.wr_data = push_entry;
    o_core_stall = i_evt_valid & ~q_if.wr_ready;
  end

  rtsp_async_fifo #(
    .W(rtsp_pkg::ENTRY_W),
    .AW(rtsp_pkg::FIFO_AW)
  ) u_queue (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_clk_link(i_clk_link),
    .i_link_reset_n(link_reset_n_q),
    .q(q_if.store)
  );

  // Link side: reset release and level synchronisers

  // Reset asserts at once and releases on the link clock
  always_ff @(posedge i_clk_link or negedge i_reset_n) begin
    if (!i_reset_n) begin
      link_rst_s1_q <= 1'b0;
      link_reset_n_q <= 1'b0;
    end else begin
      link_rst_s1_q <= 1'b1;
      link_reset_n_q <= link_rst_s1_q;
    end
  end

  logic [rtsp_pkg::SYNC_W-1:0] lvl_async;
  logic [rtsp_pkg::SYNC_W-1:0] lvl_s1_q;
  logic [rtsp_pkg::SYNC_W-1:0] lvl_s2_q;
  logic [rtsp_pkg::NIB_W-1:0] bkpt_prev_q, bkpt_hold_q, bkpt_hold_d;

  assign lvl_async = {i_status_clock_disable, i_breakpoint_status,
                      i_halted, i_emu_active, i_exc_active, i_stopped};

  always_ff @(posedge i_clk_link or negedge link_reset_n_q) begin
    if (!link_reset_n_q) begin
      lvl_s1_q <= '0;
      lvl_s2_q <= '0;
      bkpt_prev_q <= '0;
      bkpt_hold_q <= '0;
    end else begin
      lvl_s1_q <= lvl_async;
      lvl_s2_q <= lvl_s1_q;
      bkpt_prev_q <= lvl_s2_q[7:4];
      bkpt_hold_q <= bkpt_hold_d;
    end
  end

  logic stopped_l, exc_l, emu_l, halted_l, disable_l;
  logic [rtsp_pkg::NIB_W-1:0] bkpt_l;

  assign stopped_l = lvl_s2_q[0];
  assign exc_l = lvl_s2_q[1];
  assign emu_l = lvl_s2_q[2];
  assign halted_l = lvl_s2_q[3];
  // Breakpoint nibble is a word: taken only once two samples agree, so skew never shows
  assign bkpt_hold_d = (lvl_s2_q[7:4] == bkpt_prev_q) ? bkpt_prev_q : bkpt_hold_q;
  assign bkpt_l = bkpt_hold_q;
  assign disable_l = lvl_s2_q[8];

  // Mode code held while no queued entry is shown
  logic [3:0] held_code;

  always_comb begin
    if (halted_l) begin
      held_code = rtsp_pkg::ST_HALT;
    end else if (emu_l) begin
      held_code = rtsp_pkg::ST_EMU;
    end else if (exc_l) begin
      held_code = rtsp_pkg::ST_EXC;
    end else if (stopped_l) begin
      held_code = rtsp_pkg::ST_STOP;
    end else begin
      held_code = rtsp_pkg::ST_CONTINUE;
    end
  end

  // Link side: output sequencer

  rtsp_pkg::rtsp_link_state_t state_q, state_d;
  logic [3:0] status_q, status_d;
  logic [3:0] data_q, data_d;
  logic [rtsp_pkg::DATA_W-1:0] shift_q, shift_d;
  logic [rtsp_pkg::BYTES_W-1:0] bytes_q, bytes_d;
  logic [NIB_CNT_W-1:0] nib_q, nib_d;
  logic strobe_q, strobe_d;
  logic started_q, started_d;
  logic tick;

  assign pop_entry = q_if.rd_data;

  always_comb begin
    state_d = state_q;
    status_d = status_q;
    data_d = data_q;
    shift_d = shift_q;
    bytes_d = bytes_q;
    nib_d = nib_q;
    strobe_d = strobe_q;
    started_d = started_q;
    q_if.rd_ready = 1'b0;
    // start on first C, D or F
    if (!started_q && (status_q == rtsp_pkg::ST_EXC || status_q == rtsp_pkg::ST_EMU
        || status_q == rtsp_pkg::ST_HALT)) begin
      started_d = 1'b1;
    end
    if (started_q && !disable_l) begin
      strobe_d = ~strobe_q;
    end
    // Nibbles change as the strobe falls, so its rise sits mid-nibble
    // A frozen strobe must not stop the queue, or the core would stall for good
    tick = (started_q && !disable_l) ? strobe_q : 1'b1;
    if (tick) begin
      case (state_q)
        rtsp_pkg::LS_IDLE: begin
          data_d = bkpt_l;
          if (q_if.rd_valid) begin
            q_if.rd_ready = 1'b1;
            status_d = pop_entry.code;
            shift_d = pop_entry.value;
            bytes_d = pop_entry.bytes;
            if (pop_entry.bytes != '0) begin
              state_d = rtsp_pkg::LS_MARK;
            end
          end else begin
            status_d = held_code;
          end
        end
        rtsp_pkg::LS_MARK: begin
          status_d = rtsp_pkg::ST_MARKER_BASE + {1'b0, bytes_q};
          data_d = bkpt_l;
          nib_d = {bytes_q, 1'b0};
          state_d = rtsp_pkg::LS_DATA;
        end
        rtsp_pkg::LS_DATA: begin
          status_d = held_code;
          data_d = shift_q[rtsp_pkg::NIB_W-1:0];
          shift_d = shift_q >> rtsp_pkg::NIB_W;
          nib_d = nib_q - NIB_CNT_W'(1);
          if (nib_q == NIB_CNT_W'(1)) begin
            state_d = rtsp_pkg::LS_IDLE;
          end
        end
        default: begin
          state_d = rtsp_pkg::LS_IDLE;
        end
      endcase
    end
    // pins hold while disabled; the queue keeps draining
    if (disable_l) begin
      status_d = status_q;
      data_d = data_q;
    end
  end

  always_ff @(posedge i_clk_link or negedge link_reset_n_q) begin
    if (!link_reset_n_q) begin
      state_q <= rtsp_pkg::LS_IDLE;
      status_q <= rtsp_pkg::STATUS_RESET;
      data_q <= rtsp_pkg::DATA_RESET;
      shift_q <= '0;
      bytes_q <= '0;
      nib_q <= '0;
      strobe_q <= 1'b0;
      started_q <= 1'b0;
    end else begin
      state_q <= state_d;
      status_q <= status_d;
      data_q <= data_d;
      shift_q <= shift_d;
      bytes_q <= bytes_d;
      nib_q <= nib_d;
      strobe_q <= strobe_d;
      started_q <= started_d;
    end
  end

  assign o_processor_status_nibble = status_q;
  assign o_debug_data_nibble = data_q;
  assign o_status_strobe_clock = strobe_q;
  assign o_all_status_high = &status_q;
endmodule : rtsp_trace_port

// *** bench/rtsp_trace_port_checker.sv ***
// Concurrent checks on the trace port pins.
// Assumes mode and disable inputs are levels held for many link cycles.
module rtsp_trace_port_checker (
  // Clocks and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_clk_link,
  // Core side
  input wire logic i_evt_valid,
  input wire logic o_core_stall,
  input wire logic i_exc_active,
  input wire logic i_emu_active,
  input wire logic i_stopped,
  input wire logic i_halted,
  input wire logic i_status_clock_disable,
  // Trace pins
  input wire logic [3:0] o_processor_status_nibble,
  input wire logic [3:0] o_debug_data_nibble,
  input wire logic o_status_strobe_clock,
  input wire logic o_all_status_high
);
  logic seen_q, seen_d;
  logic [3:0] mode_q, mode_d, cnt_q, cnt_d;
  logic [1:0] acc_q, acc_d;

  // Fewer than two accepted events can never fill the queue
  always_comb begin
    acc_d = acc_q;
    if (i_evt_valid && !o_core_stall && acc_q != 2'h2) begin
      acc_d = acc_q + 2'h1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      acc_q <= 2'h0;
    end else begin
      acc_q <= acc_d;
    end
  end

  // Idle code by priority; the counter proves a mode has settled
  always_comb begin
    mode_d = i_halted ? 4'hf : i_emu_active ? 4'hd : i_exc_active ? 4'hc : 4'h0;
    if (mode_d == 4'h0 && i_stopped) mode_d = 4'he;
    seen_d = seen_q | (o_processor_status_nibble inside {4'hc, 4'hd, 4'hf});
    cnt_d = 4'h0;
    if (mode_d != 4'h0 && mode_d == mode_q && !i_status_clock_disable) begin
      cnt_d = (cnt_q == 4'ha) ? cnt_q : cnt_q + 4'h1;
    end
  end

  always_ff @(posedge i_clk_link or negedge i_reset_n) begin
    if (!i_reset_n) begin
      seen_q <= 1'b0;
      mode_q <= 4'h0;
      cnt_q <= 4'h0;
    end else begin
      seen_q <= seen_d;
      mode_q <= mode_d;
      cnt_q <= cnt_d;
    end
  end

  a_all_status_and: assert property (@(posedge i_clk_link) disable iff (!i_reset_n)
    o_all_status_high == &o_processor_status_nibble) else $error("all-status mismatch");
  a_no_reserved: assert property (@(posedge i_clk_link) disable iff (!i_reset_n)
    !(o_processor_status_nibble inside {4'h2, 4'h6})) else $error("reserved status code");
  a_stall_cause: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    o_core_stall |-> i_evt_valid && acc_q == 2'h2) else $error("stall before queue can be full");
  a_pins_frozen: assert property (@(posedge i_clk_link) disable iff (!i_reset_n)
    i_status_clock_disable [*5] |-> $stable(o_processor_status_nibble)
    && $stable(o_debug_data_nibble) && $stable(o_status_strobe_clock))
    else $error("pins moved while disabled");
  a_strobe_toggles: assert property (@(posedge i_clk_link) disable iff (!i_reset_n)
    (!i_status_clock_disable) [*4] ##0 $rose(o_status_strobe_clock)
    |=> $fell(o_status_strobe_clock)) else $error("strobe stopped toggling");
  a_strobe_waits: assert property (@(posedge i_clk_link) disable iff (!i_reset_n)
    !seen_q |-> !o_status_strobe_clock) else $error("strobe started too early");
  a_marker_after: assert property (@(posedge o_status_strobe_clock) disable iff (!i_reset_n)
    o_processor_status_nibble inside {[4'h8:4'hb]}
    |-> $past(o_processor_status_nibble) inside {4'h4, 4'h5, 4'h7})
    else $error("marker without a preceding capture code");
  a_mode_shown: assert property (@(posedge i_clk_link) disable iff (!i_reset_n)
    cnt_q == 4'ha |-> o_processor_status_nibble == mode_q) else $error("mode code not shown");
endmodule : rtsp_trace_port_checker

bind rtsp_trace_port rtsp_trace_port_checker u_checker (.i_clk_sys, .i_reset_n, .i_clk_link,
  .i_evt_valid, .o_core_stall, .i_exc_active, .i_emu_active, .i_stopped, .i_halted,
  .i_status_clock_disable, .o_processor_status_nibble, .o_debug_data_nibble,
  .o_status_strobe_clock, .o_all_status_high);

// *** bench/rtsp_dev_system.sv ***
// Development system model: samples the pins on the strobe's rising edge.
// Assumes no mode codes interleave with captured traffic.
module rtsp_dev_system (
  // Trace pins
  input wire logic i_status_strobe_clock,
  input wire logic [3:0] i_processor_status_nibble,
  input wire logic [3:0] i_debug_data_nibble
);
  rtsp_pkg::rtsp_entry_t cur = '0;
  rtsp_pkg::rtsp_entry_t got_q[$];
  int left = 0;
  int k = 0;
  logic pend = 1'b0;

  always @(posedge i_status_strobe_clock) begin
    if (left > 0) begin
      cur.value[4 * k +: 4] = i_debug_data_nibble;
      k++;
      left--;
      if (left == 0) begin
        got_q.push_back(cur);
        pend = 1'b0;
      end
    end else if (i_processor_status_nibble inside {[4'h8:4'hb]}) begin
      cur.bytes = 3'(i_processor_status_nibble - 4'h7);
      left = 2 * cur.bytes;
      k = 0;
    end else begin
      if (pend) got_q.push_back(cur);
      pend = 1'b0;
      if (i_processor_status_nibble inside {4'h1, 4'h3, 4'h4, 4'h5, 4'h7}) begin
        cur = '0;
        cur.code = i_processor_status_nibble;
        pend = 1'b1;
      end
    end
  end
endmodule : rtsp_dev_system

// *** bench/testbench.sv ***
// Self-checking bench: modes, freeze, then directed and random trace traffic.
// Assumes the model logs every decoded entry in display order.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk_sys = 1'b0;
  logic i_clk_link = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_evt_valid = 1'b0;
  rtsp_pkg::rtsp_event_t i_evt_kind = rtsp_pkg::EV_BEGIN;
  logic i_evt_variant = 1'b0;
  rtsp_pkg::rtsp_size_t i_evt_size = rtsp_pkg::SZ_BYTE;
  logic [31:0] i_evt_value = 32'h0;
  logic [3:0] modes = 4'h0;
  logic [1:0] i_target_bytes = 2'h0;
  logic i_status_clock_disable = 1'b0;
  logic [3:0] i_breakpoint_status = 4'h0;
  logic o_core_stall, o_status_strobe_clock, o_all_status_high;
  logic [3:0] o_processor_status_nibble, o_debug_data_nibble, b;
  logic [8:0] snap;
  rtsp_pkg::rtsp_entry_t exp_q[$];
  int n_mismatch = 0;
  int n_checks = 0;
  int n_stall = 0;
  logic stuck = 1'b0;
  int g, n;
  logic [3:0] mode_tab[5] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'hf};
  logic [3:0] code_tab[5] = '{4'hc, 4'hd, 4'hf, 4'he, 4'hf};
  logic [3:0] ev_code[7] = '{4'h1, 4'h3, 4'h4, 4'h4, 4'h5, 4'h5, 4'h7};

  always #2.5 i_clk_sys = ~i_clk_sys;
  initial begin
    #3.3;
    forever #24 i_clk_link = ~i_clk_link;
  end

  rtsp_trace_port DUT (.i_clk_sys, .i_reset_n, .i_clk_link, .i_evt_valid, .i_evt_kind,
    .i_evt_variant, .i_evt_size, .i_evt_value, .o_core_stall, .i_exc_active(modes[3]),
    .i_emu_active(modes[2]), .i_halted(modes[1]), .i_stopped(modes[0]), .i_target_bytes,
    .i_status_clock_disable, .i_breakpoint_status, .o_processor_status_nibble,
    .o_debug_data_nibble, .o_status_strobe_clock, .o_all_status_high);
  rtsp_dev_system MON (.i_status_strobe_clock(o_status_strobe_clock),
    .i_processor_status_nibble(o_processor_status_nibble),
    .i_debug_data_nibble(o_debug_data_nibble));

  function automatic rtsp_pkg::rtsp_entry_t exp_of(input int k, input logic v, input int s,
      input logic [1:0] tb, input logic [31:0] val);
    rtsp_pkg::rtsp_entry_t e;
    e = '0;
    e.code = ev_code[k];
    // Operand size or target setting gives the byte count
    if (k == 3) e.bytes = (s == 2) ? 3'h4 : 3'(s + 1);
    if ((k == 4 || k == 6) && v && tb != 2'h0) e.bytes = 3'(tb) + 3'h1;
    e.value = val & 32'((64'h1 << (8 * e.bytes)) - 64'h1);
    return e;
  endfunction : exp_of

  task automatic print_verdict;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Event stays held while stalled; accepted at the first unstalled edge
  task automatic send(input int k, input logic v, input int s, input logic [1:0] tb,
      input logic [31:0] val);
    int w;
    if (stuck) return;
    i_evt_valid <= 1'b1;
    i_evt_kind <= rtsp_pkg::rtsp_event_t'(k);
    i_evt_variant <= v;
    i_evt_size <= rtsp_pkg::rtsp_size_t'(s);
    i_target_bytes <= tb;
    i_evt_value <= val;
    w = 0;
    @(negedge i_clk_sys);
    while (o_core_stall !== 1'b0 && w < 5000) begin
      n_stall++;
      w++;
      @(negedge i_clk_sys);
    end
    if (w >= 5000) begin
      n_mismatch++;
      stuck = 1'b1;
    end
    @(posedge i_clk_sys);
    exp_q.push_back(exp_of(k, v, s, tb, val));
  endtask : send

  initial begin
    void'($urandom(50));
    repeat (20) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    repeat (40) @(posedge i_clk_sys);
    chk(o_status_strobe_clock, 1'b0);
    for (int m = 0; m < 6; m++) begin
      modes <= (m < 5) ? mode_tab[m] : 4'h0;
      repeat (150) @(posedge i_clk_sys);
      chk(o_processor_status_nibble, (m < 5) ? code_tab[m] : 4'h0);
      chk(o_all_status_high, (m < 5) ? &code_tab[m] : 1'b0);
    end
    i_status_clock_disable <= 1'b1;
    repeat (40) @(posedge i_clk_sys);
    snap = {o_processor_status_nibble, o_debug_data_nibble, o_status_strobe_clock};
    for (int i = 0; i < 6; i++) begin
      i_breakpoint_status <= 4'($urandom);
      repeat (15) @(posedge i_clk_sys);
      chk({o_processor_status_nibble, o_debug_data_nibble, o_status_strobe_clock}, snap);
    end
    i_status_clock_disable <= 1'b0;
    b = 4'($urandom);
    i_breakpoint_status <= b;
    repeat (80) @(posedge i_clk_sys);
    chk(o_debug_data_nibble, b);
    for (int k = 0; k < 7; k++) begin
      for (int j = 0; j < 5; j++) begin
        send(k, j != 0, j % 3, 2'(j), $urandom);
      end
    end
    for (int i = 0; i < 30; i++) begin
      send($urandom_range(6), 1'($urandom), $urandom_range(2), 2'($urandom), $urandom);
      g = $urandom_range(3);
      if (g != 0) begin
        i_evt_valid <= 1'b0;
        repeat (g) @(posedge i_clk_sys);
      end
    end
    i_evt_valid <= 1'b0;
    @(posedge i_clk_sys);
    chk(n_stall > 0, 1'b1);
    n = 0;
    while (MON.got_q.size() < exp_q.size() && n < 60000) begin
      @(posedge i_clk_sys);
      n++;
    end
    if (n >= 60000) n_mismatch++;
    chk(MON.got_q.size(), exp_q.size());
    foreach (exp_q[i]) chk(MON.got_q[i], exp_q[i]);
    i_reset_n <= 1'b0;
    repeat (40) @(posedge i_clk_sys);
    chk({o_processor_status_nibble, o_debug_data_nibble, o_status_strobe_clock,
      o_all_status_high}, 10'h0);
    print_verdict();
  end
endmodule : testbench
